// [hdl/ipsm_pkg.sv]
package ipsm_pkg;
  localparam int IPSM_SEL_W = 7;
  localparam int IPSM_REG_W = 16;
  localparam int IPSM_NUM_SEL = 4;
  localparam int IPSM_NUM_PINS = 128;
  // Register byte offsets
  localparam logic [11:0] IPSM_OFF_INT2 = 12'h000;
  localparam logic [11:0] IPSM_OFF_TIMER2_CLK = 12'h004;
  localparam logic [11:0] IPSM_OFF_UART1_RX = 12'h008;
  localparam logic [11:0] IPSM_OFF_UART2_RX = 12'h00C;
  localparam logic [6:0] IPSM_SEL_RESET = 7'h00;
  localparam logic [6:0] IPSM_CODE_GND = 7'h00;
  localparam logic [6:0] IPSM_CODE_COMPARATOR = 7'h01;
  localparam logic [6:0] IPSM_CODE_PIN121 = 7'h79;
  // Selector indices
  localparam int IPSM_IDX_INT2 = 0;
  localparam int IPSM_IDX_TIMER2_CLK = 1;
  localparam int IPSM_IDX_UART1_RX = 2;
  localparam int IPSM_IDX_UART2_RX = 3;

  typedef struct packed {
    logic ext_int2_in;
    logic timer2_external_clock_in;
    logic uart1_receive_in;
    logic uart2_receive_in;
  } ipsm_periph_t;
endpackage

// [hdl/ipsm_route.sv]
`timescale 1ns/10ps
module ipsm_route
  import ipsm_pkg::*;
(
  // Sources indexed by selector code
  input wire logic [IPSM_NUM_PINS-1:0] sources,
  // Selector
  input wire logic [IPSM_SEL_W-1:0] sel,
  // Routed value
  output logic routed
);
  always_comb begin
    if (sel == IPSM_CODE_GND) begin
      routed = 1'b0;
    end else begin
      routed = sources[sel];
    end
  end
endmodule

// [hdl/ipsm_top.sv]
// Contract
// - Timer2 clock follows its 7-bit selector.
// - UART1 receive follows its 7-bit selector.
// - UART2 receive has own selector, same encoding.
// - Code 1111001 picks remappable input pin 121.
// - Bits 15..7 read zero, ignore writes.
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
module ipsm_top
  import ipsm_pkg::*;
(
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Remappable pins, index = selector code
  input wire logic [IPSM_NUM_PINS-1:0] remappable_pin_n,
  // Internal source
  input wire logic comparator1_output,
  // Peripheral inputs
  output ipsm_periph_t periph_in
);
  typedef struct packed {
    logic [IPSM_NUM_PINS-1:0] sync1;
    logic [IPSM_NUM_PINS-1:0] sync2;
    logic [IPSM_NUM_SEL-1:0][IPSM_SEL_W-1:0] sel;
    logic wr_pend;
    logic [1:0] wr_idx;
    logic [31:0] rdata;
    ipsm_periph_t periph;
  } ipsm_state_t;

  ipsm_state_t st_ff;
  ipsm_state_t nxt_st;
  logic [IPSM_NUM_PINS-1:0] sources;
  logic [IPSM_NUM_SEL-1:0] routed;
  logic addr_phase;

  function automatic logic [2:0] dec_addr(input logic [11:0] a);
    unique case (a)
      IPSM_OFF_INT2: dec_addr = {1'b1, 2'(IPSM_IDX_INT2)};
      IPSM_OFF_TIMER2_CLK: dec_addr = {1'b1, 2'(IPSM_IDX_TIMER2_CLK)};
      IPSM_OFF_UART1_RX: dec_addr = {1'b1, 2'(IPSM_IDX_UART1_RX)};
      IPSM_OFF_UART2_RX: dec_addr = {1'b1, 2'(IPSM_IDX_UART2_RX)};
      default: dec_addr = 3'h0;
    endcase
  endfunction

  // Code 1 is the comparator, not a synchronised pin
  always_comb begin
    sources = st_ff.sync2;
    sources[IPSM_CODE_COMPARATOR] = comparator1_output;
  end

  genvar gi;
  generate
    for (gi = 0; gi < IPSM_NUM_SEL; gi++) begin : g_route
      ipsm_route u_route (
        .sources(sources),
        .sel(st_ff.sel[gi]),
        .routed(routed[gi])
      );
    end
  endgenerate

  assign addr_phase = hsel && hready && htrans[1];

  always_comb begin
    logic [2:0] d;
    d = dec_addr(haddr);
    nxt_st = st_ff;
    nxt_st.sync1 = remappable_pin_n;
    nxt_st.sync2 = st_ff.sync1;
    if (st_ff.wr_pend) begin
      // Only the low seven bits are stored
      nxt_st.sel[st_ff.wr_idx] = hwdata[IPSM_SEL_W-1:0];
    end
    nxt_st.wr_pend = 1'b0;
    if (addr_phase) begin
      nxt_st.wr_pend = hwrite && d[2];
      nxt_st.wr_idx = d[1:0];
      nxt_st.rdata = 32'h0000_0000;
      if (!hwrite && d[2]) begin
        nxt_st.rdata = {25'h000_0000, st_ff.sel[d[1:0]]};
      end
    end
    nxt_st.periph.ext_int2_in = routed[IPSM_IDX_INT2];
    nxt_st.periph.timer2_external_clock_in = routed[IPSM_IDX_TIMER2_CLK];
    nxt_st.periph.uart1_receive_in = routed[IPSM_IDX_UART1_RX];
    nxt_st.periph.uart2_receive_in = routed[IPSM_IDX_UART2_RX];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign hrdata = st_ff.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign periph_in = st_ff.periph;

  a_sel_reset_zero: assert property (@(posedge hclk) $rose(hresetn) |-> st_ff.sel == '0)
    else $error("selectors not zero after reset");

  a_ground_output: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && st_ff.sel[IPSM_IDX_UART1_RX] == IPSM_CODE_GND)
    |=> !periph_in.uart1_receive_in)
    else $error("grounded selector drove high");

  a_t2_route: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en |=> periph_in.timer2_external_clock_in == $past(routed[IPSM_IDX_TIMER2_CLK]))
    else $error("timer2 clock not routed");

  a_u2_pin121: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && st_ff.sel[IPSM_IDX_UART2_RX] == IPSM_CODE_PIN121)
    |=> periph_in.uart2_receive_in == $past(st_ff.sync2[121]))
    else $error("pin 121 not routed");

  a_comparator1_output_route: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && st_ff.sel[IPSM_IDX_INT2] == IPSM_CODE_COMPARATOR)
    |=> periph_in.ext_int2_in == $past(comparator1_output))
    else $error("comparator not routed");

  a_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    hrdata[31:IPSM_SEL_W] == '0)
    else $error("unimplemented bits read nonzero");

  a_write_store: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && st_ff.wr_pend && st_ff.wr_idx == 2'(IPSM_IDX_UART1_RX))
    |=> st_ff.sel[IPSM_IDX_UART1_RX] == $past(hwdata[6:0]))
    else $error("selector write lost");

  a_okay_resp: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus response not okay");

  // Synchroniser and source vector
  a_sync_first: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en |=> st_ff.sync1 == $past(remappable_pin_n))
    else $error("first sync stage lost a pin");

  a_sync_second: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en |=> st_ff.sync2 == $past(st_ff.sync1))
    else $error("second sync stage lost a pin");

  a_source_cmp: assert property (@(posedge hclk) disable iff (!hresetn)
    sources[IPSM_CODE_COMPARATOR] == comparator1_output)
    else $error("comparator missing from sources");

  a_source_pins: assert property (@(posedge hclk) disable iff (!hresetn)
    sources[0] == st_ff.sync2[0]
    && sources[IPSM_NUM_PINS-1:2] == st_ff.sync2[IPSM_NUM_PINS-1:2])
    else $error("pin missing from sources");

  // Router outputs per selector
  a_int2_gnd_mux: assert property (@(posedge hclk) disable iff (!hresetn)
    st_ff.sel[IPSM_IDX_INT2] == IPSM_CODE_GND |-> !routed[IPSM_IDX_INT2])
    else $error("int2 router not grounded");

  a_t2_gnd_mux: assert property (@(posedge hclk) disable iff (!hresetn)
    st_ff.sel[IPSM_IDX_TIMER2_CLK] == IPSM_CODE_GND |-> !routed[IPSM_IDX_TIMER2_CLK])
    else $error("timer2 router not grounded");

  a_u1_gnd_mux: assert property (@(posedge hclk) disable iff (!hresetn)
    st_ff.sel[IPSM_IDX_UART1_RX] == IPSM_CODE_GND |-> !routed[IPSM_IDX_UART1_RX])
    else $error("uart1 router not grounded");

  a_u2_gnd_mux: assert property (@(posedge hclk) disable iff (!hresetn)
    st_ff.sel[IPSM_IDX_UART2_RX] == IPSM_CODE_GND |-> !routed[IPSM_IDX_UART2_RX])
    else $error("uart2 router not grounded");

  a_int2_pin_mux: assert property (@(posedge hclk) disable iff (!hresetn)
    st_ff.sel[IPSM_IDX_INT2] == IPSM_CODE_PIN121
    |-> routed[IPSM_IDX_INT2] == st_ff.sync2[121])
    else $error("int2 router missed pin 121");

  a_t2_pin_mux: assert property (@(posedge hclk) disable iff (!hresetn)
    st_ff.sel[IPSM_IDX_TIMER2_CLK] == IPSM_CODE_PIN121
    |-> routed[IPSM_IDX_TIMER2_CLK] == st_ff.sync2[121])
    else $error("timer2 router missed pin 121");

  a_u1_pin_mux: assert property (@(posedge hclk) disable iff (!hresetn)
    st_ff.sel[IPSM_IDX_UART1_RX] == IPSM_CODE_PIN121
    |-> routed[IPSM_IDX_UART1_RX] == st_ff.sync2[121])
    else $error("uart1 router missed pin 121");

  a_u2_pin_mux: assert property (@(posedge hclk) disable iff (!hresetn)
    st_ff.sel[IPSM_IDX_UART2_RX] == IPSM_CODE_PIN121
    |-> routed[IPSM_IDX_UART2_RX] == st_ff.sync2[121])
    else $error("uart2 router missed pin 121");

  a_t2_cmp_mux: assert property (@(posedge hclk) disable iff (!hresetn)
    st_ff.sel[IPSM_IDX_TIMER2_CLK] == IPSM_CODE_COMPARATOR
    |-> routed[IPSM_IDX_TIMER2_CLK] == comparator1_output)
    else $error("timer2 router missed comparator");

  // Registered peripheral inputs
  a_int2_route: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en |=> periph_in.ext_int2_in == $past(routed[IPSM_IDX_INT2]))
    else $error("int2 input not routed");

  a_u1_route: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en |=> periph_in.uart1_receive_in == $past(routed[IPSM_IDX_UART1_RX]))
    else $error("uart1 receive not routed");

  a_u2_route: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en |=> periph_in.uart2_receive_in == $past(routed[IPSM_IDX_UART2_RX]))
    else $error("uart2 receive not routed");

  a_int2_ground: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && st_ff.sel[IPSM_IDX_INT2] == IPSM_CODE_GND) |=> !periph_in.ext_int2_in)
    else $error("int2 grounded selector drove high");

  a_t2_ground: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && st_ff.sel[IPSM_IDX_TIMER2_CLK] == IPSM_CODE_GND)
    |=> !periph_in.timer2_external_clock_in)
    else $error("timer2 grounded selector drove high");

  a_u2_ground: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && st_ff.sel[IPSM_IDX_UART2_RX] == IPSM_CODE_GND)
    |=> !periph_in.uart2_receive_in)
    else $error("uart2 grounded selector drove high");

  a_u1_pin127: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && st_ff.sel[IPSM_IDX_UART1_RX] == 7'h7F)
    |=> periph_in.uart1_receive_in == $past(st_ff.sync2[127]))
    else $error("uart1 missed pin 127");

  // Selector writes
  a_int2_store: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && st_ff.wr_pend && st_ff.wr_idx == 2'(IPSM_IDX_INT2))
    |=> st_ff.sel[IPSM_IDX_INT2] == $past(hwdata[6:0]))
    else $error("int2 selector write lost");

  a_t2_store: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && st_ff.wr_pend && st_ff.wr_idx == 2'(IPSM_IDX_TIMER2_CLK))
    |=> st_ff.sel[IPSM_IDX_TIMER2_CLK] == $past(hwdata[6:0]))
    else $error("timer2 selector write lost");

  a_u2_store: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && st_ff.wr_pend && st_ff.wr_idx == 2'(IPSM_IDX_UART2_RX))
    |=> st_ff.sel[IPSM_IDX_UART2_RX] == $past(hwdata[6:0]))
    else $error("uart2 selector write lost");

  a_sel_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && !st_ff.wr_pend) |=> $stable(st_ff.sel))
    else $error("selector changed without a write");

  a_int2_pend: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && addr_phase && hwrite && haddr == IPSM_OFF_INT2)
    |=> st_ff.wr_pend && st_ff.wr_idx == 2'(IPSM_IDX_INT2))
    else $error("int2 write not taken");

  a_t2_pend: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && addr_phase && hwrite && haddr == IPSM_OFF_TIMER2_CLK)
    |=> st_ff.wr_pend && st_ff.wr_idx == 2'(IPSM_IDX_TIMER2_CLK))
    else $error("timer2 write not taken");

  a_u1_pend: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && addr_phase && hwrite && haddr == IPSM_OFF_UART1_RX)
    |=> st_ff.wr_pend && st_ff.wr_idx == 2'(IPSM_IDX_UART1_RX))
    else $error("uart1 write not taken");

  a_u2_pend: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && addr_phase && hwrite && haddr == IPSM_OFF_UART2_RX)
    |=> st_ff.wr_pend && st_ff.wr_idx == 2'(IPSM_IDX_UART2_RX))
    else $error("uart2 write not taken");

  a_read_no_pend: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && addr_phase && !hwrite) |=> !st_ff.wr_pend)
    else $error("read started a write");

  // Read data
  a_int2_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && addr_phase && !hwrite && haddr == IPSM_OFF_INT2)
    |=> hrdata == {25'h000_0000, $past(st_ff.sel[IPSM_IDX_INT2])})
    else $error("int2 read data wrong");

  a_t2_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && addr_phase && !hwrite && haddr == IPSM_OFF_TIMER2_CLK)
    |=> hrdata == {25'h000_0000, $past(st_ff.sel[IPSM_IDX_TIMER2_CLK])})
    else $error("timer2 read data wrong");

  a_u1_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && addr_phase && !hwrite && haddr == IPSM_OFF_UART1_RX)
    |=> hrdata == {25'h000_0000, $past(st_ff.sel[IPSM_IDX_UART1_RX])})
    else $error("uart1 read data wrong");

  a_u2_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && addr_phase && !hwrite && haddr == IPSM_OFF_UART2_RX)
    |=> hrdata == {25'h000_0000, $past(st_ff.sel[IPSM_IDX_UART2_RX])})
    else $error("uart2 read data wrong");

  a_unmapped_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && addr_phase && !hwrite && haddr != IPSM_OFF_INT2
    && haddr != IPSM_OFF_TIMER2_CLK && haddr != IPSM_OFF_UART1_RX
    && haddr != IPSM_OFF_UART2_RX) |=> hrdata == '0)
    else $error("unmapped read not zero");

  a_rdata_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && !addr_phase) |=> $stable(hrdata))
    else $error("read data moved between transfers");

  a_reset_outputs: assert property (@(posedge hclk)
    $rose(hresetn) |-> periph_in == '0 && hrdata == '0)
    else $error("outputs not zero after reset");
endmodule

// [test/ipsm_pins.sv]
`timescale 1ns/10ps
module ipsm_pins (
  // Clock
  input wire logic hclk,
  // Levels asked for by the bench
  input wire logic [127:0] pat,
  input wire logic cmp_lvl,
  // Pins and comparator
  output logic [127:0] pins,
  output logic cmp
);
  // Far side moves on the rising edge of hclk, one cycle after the bench sets it
  always_ff @(posedge hclk) begin
    pins <= pat;
    cmp <= cmp_lvl;
  end
endmodule

// [test/tb.sv]
`timescale 1ns/10ps
module tb;
  import ipsm_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, cmp_lvl = 0, hreadyout, hresp, cmp;
  logic [11:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic [31:0] hwdata = '0, hrdata, r;
  logic [127:0] pat = '0, pins;
  ipsm_periph_t periph_in;
  int n_errors = 0, checks_done = 0, cyc = 0;
  initial forever #5 hclk = ~hclk;
  ipsm_pins pm (.hclk(hclk), .pat(pat), .cmp_lvl(cmp_lvl), .pins(pins), .cmp(cmp));
  ipsm_top uut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .remappable_pin_n(pins),
    .comparator1_output(cmp), .periph_in(periph_in));
  task chk(string nm, logic [31:0] s, logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task xfer(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp", 32'(hresp), 0);
  endtask
  task settle;
    repeat (6) @(posedge hclk);
  endtask
  task t_reset;
    for (int i = 0; i < 4; i++) begin
      xfer(0, 12'(4 * i), 0);
      chk("sel", r, 0);
    end
    chk("periph", 32'(periph_in), 0);
    $display("t_reset done");
  endtask
  task t_bits;
    xfer(1, IPSM_OFF_UART1_RX, 32'hFFFFFFFF);
    xfer(0, IPSM_OFF_UART1_RX, 0);
    chk("u1sel", r, 32'h7F);
    pat <= 128'h1 << 127;
    settle();
    chk("uart1_receive_in", 32'(periph_in.uart1_receive_in), 1);
    $display("t_bits done");
  endtask
  task t_121;
    for (int i = 0; i < 4; i++) xfer(1, 12'(4 * i), 32'h79);
    pat <= 128'h1 << 121;
    settle();
    chk("all", 32'(periph_in), 32'hF);
    pat <= '0;
    settle();
    chk("all", 32'(periph_in), 0);
    $display("t_121 done");
  endtask
  task t_cmp_gnd;
    xfer(1, IPSM_OFF_TIMER2_CLK, 1);
    pat <= ~128'h2;
    settle();
    chk("t2", 32'(periph_in.timer2_external_clock_in), 0);
    cmp_lvl <= 1;
    settle();
    chk("t2", 32'(periph_in.timer2_external_clock_in), 1);
    for (int i = 0; i < 4; i++) xfer(1, 12'(4 * i), 0);
    settle();
    chk("gnd", 32'(periph_in), 0);
    xfer(1, 12'h010, 32'hFFFFFFFF);
    xfer(0, 12'h010, 0);
    chk("unmapped", r, 0);
    $display("t_cmp_gnd done");
  endtask
  task results;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc > 2000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    t_reset();
    t_bits();
    t_121();
    t_cmp_gnd();
    results();
  end
endmodule
